/* File: verilog/adc_seq_regs.svh */
// Constants of the ADC conversion sequencer: field positions, reset values and timing counts
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

`define ADC_MCLK_MHZ      40
`define ADC_SAMPLE_NS     500
`define ADC_SAMPLE_CYC    ((`ADC_SAMPLE_NS * `ADC_MCLK_MHZ) / 1000)
`define ADC_FIFO_DEPTH    17
`define ADC_TEMP11_SHOW   5'h16
`define ADC_CLKMODE_RST   2'h2
`define ADC_REFMODE_RST   2'h0
`define ADC_AVGSEL_RST    2'h0
`define CMD_CONV_TEMP     0
`define CMD_CONV_SCAN_LSB 1
`define CMD_CONV_CH_LSB   3
`define CMD_SET_BIPOLAR   1
`define CMD_SET_REF_LSB   2
`define CMD_SET_CLK_LSB   4
`define CMD_AVG_SEL_LSB   2
`define CMD_AVG_EN        4
`define CMD_RST_FIFOCLR   2
`define CMD_RST_BIASKEEP  3

`endif

/* File: verilog/adc_seq_pkg.sv */
// Types shared by the ADC conversion sequencer
package adc_seq_pkg;

	typedef enum logic [1:0]
	{
		CM_CNV_SCAN = 2'b00,
		CM_CNV_ACQ  = 2'b01,
		CM_CMD_SCAN = 2'b10,
		CM_SCLK     = 2'b11
	} clk_mode_e;

	typedef enum logic [1:0]
	{
		S_IDLE   = 2'b00,
		S_ARM    = 2'b01,
		S_SAMPLE = 2'b10,
		S_CONV   = 2'b11
	} scan_state_e;

	typedef struct packed
	{
		clk_mode_e  clkMode;
		logic [1:0] refMode;
		logic       bipolar;
		logic       avgEn;
		logic [1:0] avgSel;
		logic       biasKeepOn;
	} cfg_s;

	typedef struct packed
	{
		logic [3:0] lastCh;
		logic       single;
		logic       temp;
	} scan_s;

	typedef struct packed
	{
		logic [3:0]  pad;
		logic [11:0] code;
	} entry_s;

endpackage : adc_seq_pkg

/* File: verilog/bit_sync.sv */
// Two-stage level synchroniser, one chain per bit
`timescale 1ns/1ps
`default_nettype none

module bit_sync
#(
	parameter int W = 1
)
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	input  wire logic [W-1:0] rstVal,
	output var  logic [W-1:0] q
);

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			logic metaQ;
			always_ff @(posedge clk)
			begin
				if (!rst_n)
				begin
					// Idle level at reset, so no false edge follows release
					metaQ <= 1'b0;
					q[i]  <= rstVal[i];
				end
				else
				begin
					metaQ <= d[i] ^ rstVal[i];
					q[i]  <= metaQ ^ rstVal[i];
				end
			end
		end
	endgenerate

endmodule : bit_sync

`default_nettype wire

/* File: verilog/adc_conversion_sequencer.sv */
// ADC conversion sequencer: serial link, scan engine, result FIFO and end-of-conversion
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_regs.svh"

module adc_conversion_sequencer
	import adc_seq_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        sclk,
	input  wire logic        csN,
	input  wire logic        mosi,
	input  wire logic        convert_start_n,
	input  wire logic        adcDone,
	input  wire logic [11:0] adcData,
	output logic             miso,
	output logic             eocN,
	output logic             adcStart,
	output logic [3:0]       adcChan,
	output logic             adcTemp,
	output logic             analogAwake
);

	logic [2:0]  rxCntQ;
	logic [2:0]  txCntQ;
	logic [6:0]  rxShQ;
	logic [7:0]  rxByteQ;
	logic [7:0]  txShQ;
	logic [7:0]  curByteQ;
	logic        rxTglQ;
	logic        txTglQ;
	logic        doutFallQ;
	logic        doutRiseQ;
	logic        csS;
	logic        cnvS;
	logic        rxTglS;
	logic        txTglS;
	logic        csPrevQ;
	logic        cnvPrevQ;
	logic        rxPrevQ;
	logic        txPrevQ;
	cfg_s        cfgQ;
	scan_s       scanQ;
	scan_state_e stateQ;
	logic [3:0]  chanQ;
	logic        tempPendQ;
	logic [4:0]  sampleCntQ;
	logic [4:0]  avgCntQ;
	logic [16:0] sumQ;
	entry_s      memQ [0:`ADC_FIFO_DEPTH-1];
	logic [4:0]  wrPtrQ;
	logic [4:0]  rdPtrQ;
	logic [4:0]  cntQ;
	entry_s      holdQ;
	logic        loSelQ;
	logic [4:0]  byteCnt11Q;
	logic [1:0]  nopCntQ;
	logic        eocNQ;
	logic        awakeQ;

	// ----------------------------------------------------------------
	// Link side, clocked by the serial clock
	// ----------------------------------------------------------------
	// Counters restart on every frame; a byte cut short never reaches the decode
	always_ff @(posedge sclk or posedge csN)
	begin
		if (csN)
		begin
			rxCntQ <= 3'h0;
			rxShQ  <= 7'h00;
		end
		else
		begin
			rxCntQ <= rxCntQ + 3'h1;
			rxShQ  <= {rxShQ[5:0], mosi};
		end
	end

	always_ff @(posedge sclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rxByteQ <= 8'h00;
			rxTglQ  <= 1'b0;
		end
		else if (!csN && rxCntQ == 3'h7)
		begin
			rxByteQ <= {rxShQ, mosi};
			rxTglQ  <= ~rxTglQ;
		end
	end

	// A byte is counted as consumed when its first bit leaves, so a partial
	// read drops the rest of that byte and the next read starts on the next one
	always_ff @(negedge sclk or posedge csN)
	begin
		if (csN)
		begin
			txCntQ    <= 3'h0;
			txShQ     <= 8'h00;
			doutFallQ <= 1'b0;
		end
		else if (txCntQ == 3'h0)
		begin
			txCntQ    <= txCntQ + 3'h1;
			doutFallQ <= curByteQ[7];
			txShQ     <= {curByteQ[6:0], 1'b0};
		end
		else
		begin
			txCntQ    <= txCntQ + 3'h1;
			doutFallQ <= txShQ[7];
			txShQ     <= {txShQ[6:0], 1'b0};
		end
	end

	always_ff @(negedge sclk or negedge rst_n)
	begin
		if (!rst_n)
			txTglQ <= 1'b0;
		else if (!csN && txCntQ == 3'h0)
			txTglQ <= ~txTglQ;
	end

	always_ff @(posedge sclk or posedge csN)
	begin
		if (csN)
			doutRiseQ <= 1'b0;
		else
			doutRiseQ <= doutFallQ;
	end

	// Mode is static while a frame runs, so selecting the edge here is safe
	assign miso = (cfgQ.clkMode == CM_SCLK) ? doutRiseQ : doutFallQ;

	// ----------------------------------------------------------------
	// Crossings into the system clock
	// ----------------------------------------------------------------
	bit_sync #(.W(4)) u_sync
	(
		.clk    (mclk),
		.rst_n  (rst_n),
		.d      ({csN, convert_start_n, rxTglQ, txTglQ}),
		.rstVal (4'hc),
		.q      ({csS, cnvS, rxTglS, txTglS})
	);

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			csPrevQ  <= 1'b1;
			cnvPrevQ <= 1'b1;
			rxPrevQ  <= 1'b0;
			txPrevQ  <= 1'b0;
		end
		else
		begin
			csPrevQ  <= csS;
			cnvPrevQ <= cnvS;
			rxPrevQ  <= rxTglS;
			txPrevQ  <= txTglS;
		end
	end

	logic csFall, cnvFall, cnvRise, cmdEv, consEv;
	logic isConv, isSetup, isAvg, isRst, isNop, mode11, mode01;
	assign csFall  = csPrevQ & ~csS;
	assign cnvFall = cnvPrevQ & ~cnvS;
	assign cnvRise = ~cnvPrevQ & cnvS;
	// The received byte stays put for eight serial clocks after its toggle
	assign cmdEv   = rxTglS ^ rxPrevQ;
	assign consEv  = txTglS ^ txPrevQ;
	assign isConv  = rxByteQ[7];
	assign isSetup = rxByteQ[7:6] == 2'h1;
	assign isAvg   = rxByteQ[7:5] == 3'h1;
	assign isRst   = rxByteQ[7:4] == 4'h1;
	assign isNop   = rxByteQ == 8'h00;
	assign mode11  = cfgQ.clkMode == CM_SCLK;
	assign mode01  = cfgQ.clkMode == CM_CNV_ACQ;

	// ----------------------------------------------------------------
	// Configuration, written in any state of the scan
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			cfgQ.clkMode    <= clk_mode_e'(`ADC_CLKMODE_RST);
			cfgQ.refMode    <= `ADC_REFMODE_RST;
			cfgQ.bipolar    <= 1'b0;
			cfgQ.avgEn      <= 1'b0;
			cfgQ.avgSel     <= `ADC_AVGSEL_RST;
			cfgQ.biasKeepOn <= 1'b0;
		end
		else if (cmdEv && isSetup)
		begin
			cfgQ.clkMode <= clk_mode_e'(rxByteQ[`CMD_SET_CLK_LSB +: 2]);
			cfgQ.refMode <= rxByteQ[`CMD_SET_REF_LSB +: 2];
			cfgQ.bipolar <= rxByteQ[`CMD_SET_BIPOLAR];
		end
		else if (cmdEv && isAvg)
		begin
			cfgQ.avgEn  <= rxByteQ[`CMD_AVG_EN];
			cfgQ.avgSel <= rxByteQ[`CMD_AVG_SEL_LSB +: 2];
		end
		else if (cmdEv && isRst)
			cfgQ.biasKeepOn <= rxByteQ[`CMD_RST_BIASKEEP];
	end

	// ----------------------------------------------------------------
	// Scan engine
	// ----------------------------------------------------------------
	logic [5:0]  avgN;
	logic [4:0]  avgLast;
	logic [2:0]  avgShift;
	logic [16:0] sumNext;
	logic [11:0] avgCode;
	logic [11:0] outCode;
	logic        itemDone, chanDone, scanEnd, convEnd, startCmd;
	always_comb
	begin
		avgN     = cfgQ.avgEn ? (6'h4 << cfgQ.avgSel) : 6'h1;
		avgLast  = 5'(avgN - 6'h1);
		avgShift = cfgQ.avgEn ? (3'h2 + {1'b0, cfgQ.avgSel}) : 3'h0;
		sumNext  = sumQ + {5'h00, adcData};
		avgCode  = 12'(sumNext >> avgShift);
	end
	// Analog delivers offset binary; flipping the MSB gives two's complement
	assign outCode  = (tempPendQ || cfgQ.bipolar) ? {~avgCode[11], avgCode[10:0]} : avgCode;
	assign convEnd  = (stateQ == S_CONV) && adcDone;
	assign itemDone = tempPendQ || (avgCntQ == avgLast);
	assign chanDone = scanQ.single || (chanQ == scanQ.lastCh);
	assign scanEnd  = mode11 || (itemDone && !tempPendQ && chanDone);
	assign startCmd = (stateQ == S_IDLE) && cmdEv && isConv;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			stateQ     <= S_IDLE;
			scanQ      <= '0;
			chanQ      <= 4'h0;
			tempPendQ  <= 1'b0;
			sampleCntQ <= 5'h00;
			avgCntQ    <= 5'h00;
			sumQ       <= 17'h00000;
		end
		else
		begin
			case (stateQ)
				S_IDLE:
				begin
					if (startCmd)
					begin
						scanQ.lastCh <= rxByteQ[`CMD_CONV_CH_LSB +: 4];
						scanQ.single <= mode11 || (rxByteQ[`CMD_CONV_SCAN_LSB +: 2] != 2'h0);
						scanQ.temp   <= rxByteQ[`CMD_CONV_TEMP];
						chanQ        <= (mode11 || rxByteQ[`CMD_CONV_SCAN_LSB +: 2] != 2'h0) ?
						                rxByteQ[`CMD_CONV_CH_LSB +: 4] : 4'h0;
						tempPendQ    <= rxByteQ[`CMD_CONV_TEMP];
						avgCntQ      <= 5'h00;
						sumQ         <= 17'h00000;
						sampleCntQ   <= 5'h00;
						stateQ       <= (cfgQ.clkMode == CM_CMD_SCAN || mode11) ? S_SAMPLE : S_ARM;
					end
				end
				S_ARM:
				begin
					sampleCntQ <= 5'h00;
					if (cnvRise)
						stateQ <= S_SAMPLE;
				end
				S_SAMPLE:
				begin
					sampleCntQ <= sampleCntQ + 5'h01;
					if (sampleCntQ == 5'(`ADC_SAMPLE_CYC - 1))
						stateQ <= S_CONV;
				end
				S_CONV:
				begin
					if (adcDone)
					begin
						sampleCntQ <= 5'h00;
						if (tempPendQ || mode11)
							tempPendQ <= 1'b0;
						else if (itemDone)
						begin
							avgCntQ <= 5'h00;
							sumQ    <= 17'h00000;
							if (!chanDone)
								chanQ <= chanQ + 4'h1;
						end
						else
						begin
							avgCntQ <= avgCntQ + 5'h01;
							sumQ    <= sumNext;
						end
						if (scanEnd)
							stateQ <= S_IDLE;
						else if (mode01)
							stateQ <= S_ARM;
						else
							stateQ <= S_SAMPLE;
					end
				end
				default:
					stateQ <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			adcStart <= 1'b0;
			adcChan  <= 4'h0;
			adcTemp  <= 1'b0;
		end
		else
		begin
			adcStart <= (stateQ == S_SAMPLE) && (sampleCntQ == 5'(`ADC_SAMPLE_CYC - 1));
			adcChan  <= chanQ;
			adcTemp  <= tempPendQ;
		end
	end

	// ----------------------------------------------------------------
	// Result FIFO and the one-word holder of serial-clock mode
	// ----------------------------------------------------------------
	logic   fifoWr, fifoPop, fifoClr;
	entry_s wrEntry;
	entry_s headW;
	assign wrEntry = '{pad: 4'h0, code: outCode};
	assign fifoWr  = convEnd && itemDone && !mode11 && (cntQ != 5'(`ADC_FIFO_DEPTH));
	assign fifoPop = consEv && loSelQ && !mode11 && (cntQ != 5'h00);
	assign fifoClr = (startCmd && !mode11) || (cmdEv && isRst && rxByteQ[`CMD_RST_FIFOCLR]);

	always_ff @(posedge mclk)
	begin
		if (fifoWr)
			memQ[wrPtrQ] <= wrEntry;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n || fifoClr)
		begin
			wrPtrQ <= 5'h00;
			rdPtrQ <= 5'h00;
			cntQ   <= 5'h00;
		end
		else
		begin
			if (fifoWr)
				wrPtrQ <= (wrPtrQ == 5'(`ADC_FIFO_DEPTH - 1)) ? 5'h00 : wrPtrQ + 5'h01;
			if (fifoPop)
				rdPtrQ <= (rdPtrQ == 5'(`ADC_FIFO_DEPTH - 1)) ? 5'h00 : rdPtrQ + 5'h01;
			cntQ <= cntQ + 5'(fifoWr) - 5'(fifoPop);
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			holdQ <= '0;
		else if (startCmd && mode11)
			holdQ <= '0;
		else if (convEnd && mode11)
			holdQ <= wrEntry;
	end

	// ----------------------------------------------------------------
	// Byte offered to the link
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			loSelQ     <= 1'b0;
			byteCnt11Q <= 5'h00;
		end
		else if (startCmd || fifoClr)
		begin
			loSelQ     <= 1'b0;
			byteCnt11Q <= 5'h00;
		end
		else if (consEv)
		begin
			loSelQ <= ~loSelQ;
			if (byteCnt11Q != 5'h1f)
				byteCnt11Q <= byteCnt11Q + 5'h01;
		end
	end

	always_comb
	begin
		if (mode11)
			headW = (!scanQ.temp || byteCnt11Q >= `ADC_TEMP11_SHOW) ? holdQ : '0;
		else
			headW = (cntQ != 5'h00) ? memQ[rdPtrQ] : '0;
	end

	// Reloaded every system clock and moves on to the next byte once a byte start is seen; the link samples it only at a byte start
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			curByteQ <= 8'h00;
		else
			curByteQ <= loSelQ ? headW[7:0] : headW[15:8];
	end

	// ----------------------------------------------------------------
	// End of conversion and analog power
	// ----------------------------------------------------------------
	logic eocSet, eocClr, nopPd;
	assign eocSet = convEnd && !mode11 && (scanEnd || mode01);
	assign eocClr = csFall || (cnvFall && (cfgQ.clkMode == CM_CNV_SCAN || mode01));
	assign nopPd  = mode11 && cmdEv && isNop && nopCntQ == 2'h1 && !cfgQ.biasKeepOn && !scanQ.temp;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			eocNQ <= 1'b1;
		else if (eocSet)
			eocNQ <= 1'b0;
		else if (eocClr)
			eocNQ <= 1'b1;
	end
	assign eocN = eocNQ;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			nopCntQ <= 2'h0;
		else if (cmdEv && isNop && nopCntQ != 2'h3)
			nopCntQ <= nopCntQ + 2'h1;
		else if (cmdEv && !isNop)
			nopCntQ <= 2'h0;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			awakeQ <= 1'b0;
		else if (stateQ == S_SAMPLE)
			awakeQ <= 1'b1;
		else if (eocSet || nopPd)
			awakeQ <= 1'b0;
	end
	assign analogAwake = awakeQ;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence sampleEntryS;
		(stateQ == S_ARM || stateQ == S_IDLE) ##1 stateQ == S_SAMPLE;
	endsequence
	sequence eocQuietS;
		!eocNQ && !eocClr && !eocSet;
	endsequence

	eoc_set_a: assert property (eocSet |=> !eocNQ)
		else $error("end flag not set after scan end");
	eoc_hold_a: assert property (eocQuietS |=> !eocNQ)
		else $error("end flag released without a clear event");
	sample_wait_a: assert property (sampleEntryS |-> (!adcStart)[*8])
		else $error("conversion started before sampling window");
	fifo_zeros_a: assert property (fifoWr |=> memQ[$past(wrPtrQ)].pad == 4'h0 &&
		memQ[$past(wrPtrQ)].code == $past(outCode))
		else $error("result word lacks four leading zeros");
	temp_first_a: assert property (fifoWr && scanQ.temp && cntQ == 5'h00 |-> tempPendQ)
		else $error("temperature result not stored first");
	mode_reset_a: assert property ($past(!rst_n) |-> cfgQ.clkMode == CM_CMD_SCAN)
		else $error("clock mode not 10 after reset");
	sclk_nofifo_a: assert property (mode11 |-> !fifoWr ##1 !fifoWr)
		else $error("FIFO written in serial-clock mode");
	avg_write_a: assert property (fifoWr && !tempPendQ |-> avgCntQ == avgLast)
		else $error("averaged result written early");
	pop_order_a: assert property (fifoPop && !fifoClr |=> rdPtrQ != $past(rdPtrQ))
		else $error("read pointer stuck on consumed entry");
	nop_down_a: assert property (nopPd && stateQ != S_SAMPLE |=> !analogAwake)
		else $error("analog not powered down after two NOP bytes");

endmodule : adc_conversion_sequencer

`default_nettype wire

/* File: testbench/adc_host_model.sv */
// Serial host partner: chip select, serial clock, data out and convert-start pin
`timescale 1ns/1ps
`default_nettype none

module adc_host_model
(
	output logic     sclk,
	output logic     csN,
	output logic     mosi,
	output logic     convert_start_n,
	input  wire logic miso,
	input  wire logic mclk
);
	localparam int HALF = 16;

	initial
	begin
		sclk = 1'b1;
		csN = 1'b1;
		mosi = 1'b0;
		convert_start_n = 1'b1;
	end

	// Frame edges sit on the system clock's falling edge; the gap lets the link resync
	task automatic select(input logic on);
		@(negedge mclk);
		csN = !on;
		if (!on)
			mosi = !mosi;
		repeat (5) @(negedge mclk);
	endtask : select

	// Serial clock idles high and only runs inside a frame
	task automatic shift(input logic [7:0] tx, input int nBits, input logic m11,
		output logic [7:0] rx);
		rx = 8'h00;
		#7;
		for (int i = 7; i >= 8 - nBits; i--)
		begin
			sclk = 1'b0;
			mosi = tx[i];
			#HALF;
			if (!m11)
				rx[i] = miso;
			sclk = 1'b1;
			#(HALF / 2);
			if (m11)
				rx[i] = miso;
			#(HALF / 2);
		end
	endtask : shift

	// Low time covers the synchroniser and the acquisition minimum
	task automatic cnvPulse(input int lowNs);
		@(negedge mclk);
		convert_start_n = 1'b0;
		#lowNs;
		@(negedge mclk);
		convert_start_n = 1'b1;
	endtask : cnvPulse
endmodule : adc_host_model
`default_nettype wire

/* File: testbench/adc_conversion_sequencer_tb.sv */
// Self-checking bench of the ADC conversion sequencer
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_sequencer_tb;
	import adc_seq_pkg::*;
	logic        mclk, rst_n, sclk, csN, mosi, convert_start_n, adcDone;
	logic        miso, eocN, adcStart, adcTemp, analogAwake;
	logic [11:0] adcData;
	logic [3:0]  adcChan;
	logic [15:0] lfsr = 16'h0063;
	logic [11:0] recCode[$];
	logic        recTemp[$];
	logic [3:0]  recChan[$];
	int          doneCnt = 0;
	int          n_mismatch = 0;
	int          n_checks = 0;

	adc_conversion_sequencer i_adc_conversion_sequencer (.mclk(mclk), .rst_n(rst_n),
		.sclk(sclk), .csN(csN), .mosi(mosi), .convert_start_n(convert_start_n),
		.adcDone(adcDone), .adcData(adcData), .miso(miso), .eocN(eocN),
		.adcStart(adcStart), .adcChan(adcChan), .adcTemp(adcTemp),
		.analogAwake(analogAwake));
	adc_host_model i_adc_host_model (.sclk(sclk), .csN(csN), .mosi(mosi),
		.convert_start_n(convert_start_n), .miso(miso), .mclk(mclk));

	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	function automatic logic [15:0] nextRand(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nextRand

	function automatic logic [15:0] fmt(input logic [11:0] code, input logic inv);
		return {4'h0, code ^ {inv, 11'h000}};
	endfunction : fmt

	// Converter stand-in: data changes every cycle so no stale code can match
	always @(negedge mclk)
	begin
		lfsr <= nextRand(lfsr);
		adcData <= lfsr[11:0];
		adcDone <= (doneCnt == 1);
		if (doneCnt == 1)
			recCode.push_back(lfsr[11:0]);
		if (doneCnt > 0)
			doneCnt <= doneCnt - 1;
		if (adcStart === 1'b1)
		begin
			recChan.push_back(adcChan);
			recTemp.push_back(adcTemp);
			doneCnt <= 6;
		end
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict

	task automatic send(input logic [7:0] b, input int nBits);
		logic [7:0] rx;
		i_adc_host_model.select(1'b1);
		i_adc_host_model.shift(b, nBits, 1'b0, rx);
		i_adc_host_model.select(1'b0);
	endtask : send

	task automatic readWord(input logic m11, output logic [15:0] w);
		logic [7:0] hi;
		logic [7:0] lo;
		i_adc_host_model.shift(8'h00, 8, m11, hi);
		i_adc_host_model.shift(8'h00, 8, m11, lo);
		w = {hi, lo};
	endtask : readWord

	// Host waits for end of conversion before selecting the device
	task automatic waitEoc();
		int k;
		k = 0;
		while (eocN !== 1'b0 && k < 4000)
		begin
			@(negedge mclk);
			k++;
		end
		check("end of conversion", {15'h0, eocN}, 16'h0);
	endtask : waitEoc

	task automatic readFifo(input int first, input int n, input logic bip, input logic m11);
		logic [15:0] w;
		i_adc_host_model.select(1'b1);
		check("eoc after select", {15'h0, eocN}, 16'h1);
		for (int j = first; j < first + n; j++)
		begin
			readWord(m11, w);
			check("result word", w, fmt(recCode[j], bip | recTemp[j]));
		end
		i_adc_host_model.select(1'b0);
	endtask : readFifo

	initial
	begin
		#1_000_000;
		n_mismatch++;
		print_verdict();
	end

	initial
	begin
		logic [15:0] w;
		logic [7:0]  b;
		logic [3:0]  ch;
		int          base;
		logic [13:0] sum;
		rst_n = 1'b0;
		repeat (12) @(negedge mclk);
		check("reset outputs", {eocN, adcStart, analogAwake}, 16'h4);
		rst_n = 1'b1;
		repeat (4) @(negedge mclk);
		// Default mode: command alone runs temperature then channels 0..2
		send(8'h91, 8);
		waitEoc();
		check("record count", 16'(recCode.size()), 16'h4);
		check("temperature first", {15'h0, recTemp[0]}, 16'h1);
		for (int j = 1; j < 4; j++)
			check("scan channel", {12'h0, recChan[j]}, 16'(j - 1));
		readFifo(0, 4, 1'b0, 1'b0);
		// Cut reads: a cut first byte and a cut second byte
		base = recCode.size();
		send(8'h90, 8);
		waitEoc();
		i_adc_host_model.select(1'b1);
		i_adc_host_model.shift(8'h00, 3, 1'b0, b);
		check("partial high", b, 8'h00);
		i_adc_host_model.select(1'b0);
		i_adc_host_model.select(1'b1);
		i_adc_host_model.shift(8'h00, 8, 1'b0, b);
		check("byte after cut", b, recCode[base][7:0]);
		i_adc_host_model.shift(8'h00, 8, 1'b0, b);
		i_adc_host_model.shift(8'h00, 5, 1'b0, b);
		i_adc_host_model.select(1'b0);
		i_adc_host_model.select(1'b1);
		readWord(1'b0, w);
		check("entry after cut", w[11:0], recCode[base + 2]);
		i_adc_host_model.select(1'b0);
		// Cut setup write keeps unipolar; full write selects bipolar
		ch = lfsr[3:0];
		send(8'h62, 5);
		base = recCode.size();
		send({1'b1, ch, 3'b010}, 8);
		waitEoc();
		check("single channel", {12'h0, recChan[base]}, {12'h0, ch});
		readFifo(base, 1, 1'b0, 1'b0);
		send(8'h62, 8);
		base = recCode.size();
		send({1'b1, ch, 3'b010}, 8);
		waitEoc();
		readFifo(base, 1, 1'b1, 1'b0);
		// Mode 00: nothing starts until the convert-start pulse
		send(8'h40, 8);
		base = recCode.size();
		send(8'h88, 8);
		repeat (60) @(negedge mclk);
		check("armed only", 16'(recCode.size()), 16'(base));
		i_adc_host_model.cnvPulse(100);
		waitEoc();
		readFifo(base, 2, 1'b0, 1'b0);
		// Mode 01 with averaging of four: one pulse per conversion
		send(8'h50, 8);
		send(8'h30, 8);
		base = recCode.size();
		send(8'h9a, 8);
		for (int p = 0; p < 4; p++)
		begin
			i_adc_host_model.cnvPulse(1500);
			if (p > 0)
				check("eoc after pulse", {15'h0, eocN}, 16'h1);
			waitEoc();
		end
		sum = 14'h0;
		for (int j = base; j < base + 4; j++)
			sum = sum + recCode[j];
		i_adc_host_model.select(1'b1);
		readWord(1'b0, w);
		check("averaged result", w, {4'h0, sum[13:2]});
		i_adc_host_model.select(1'b0);
		send(8'h20, 8);
		// Mode 11: no FIFO, rising-edge output, two NOPs power down
		send(8'h70, 8);
		for (int k = 0; k < 2; k++)
		begin
			base = recCode.size();
			send(8'h8a, 8);
			repeat (60) @(negedge mclk);
			i_adc_host_model.select(1'b1);
			readWord(1'b1, w);
			check("serial clock result", w, fmt(recCode[base], 1'b0));
			i_adc_host_model.select(1'b0);
			repeat (6) @(negedge mclk);
			check("analog power", {15'h0, analogAwake}, k);
			send(8'h18, 8);
		end
		// Mode 11 temperature: 22 zero bytes, then the result on bytes 23 and 24
		base = recCode.size();
		send(8'h83, 8);
		repeat (60) @(negedge mclk);
		i_adc_host_model.select(1'b1);
		for (int k = 0; k < 11; k++)
		begin
			readWord(1'b1, w);
			check("temperature lead", w, 16'h0000);
		end
		readWord(1'b1, w);
		check("temperature result", w, fmt(recCode[base], recTemp[base]));
		i_adc_host_model.select(1'b0);
		print_verdict();
	end
endmodule : adc_conversion_sequencer_tb
`default_nettype wire
